// *** rtl/avr_classify.v ***
// Range classifier for one 16-bit signed channel code.
// Assumes the range select is stable while the code is sampled.
`timescale 1ns/1ps
`default_nettype none
`include "avr_defs.vh"
module avr_classify (
   input wire [15:0] code,
   input wire [1:0] range_sel,
   output reg [1:0] cls
);
   function lt_s;
      input [15:0] a;
      input [15:0] b;
      begin
         lt_s = $signed(a) < $signed(b);
      end
   endfunction

   reg [15:0] bot;
   always @*
   begin
      case (range_sel)
         `AVR_RANGE_LIVEZERO: bot = `AVR_LIVE_BOT;
         `AVR_RANGE_UNIPOLAR: bot = `AVR_UNI_BOT;
         default: bot = `AVR_BIP_BOT;
      endcase
      // Unipolar zero is the lowest legal code, so -1 is already underflow
      if (lt_s(`AVR_OVR_TOP, code))
         cls = `AVR_CLASS_HIGH;
      else if (lt_s(code, bot))
         cls = `AVR_CLASS_LOW;
      else
         cls = `AVR_CLASS_OK;
   end
endmodule // avr_classify
`default_nettype wire

// *** rtl/avr_defs.vh ***
// Constants for the analog value range handler.
// Assumes 16-bit two's complement channel codes and a 40 MHz module clock.
`ifndef AVR_DEFS_VH
`define AVR_DEFS_VH
`define AVR_CODE_OVERFLOW 16'h7fff
`define AVR_CODE_UNDERFLOW 16'h8000
`define AVR_CODE_ZERO 16'h0000
`define AVR_OVR_TOP 16'h7eff
`define AVR_BIP_BOT 16'h8100
`define AVR_LIVE_BOT 16'he500
`define AVR_UNI_BOT 16'h0000
`define AVR_RANGE_BIPOLAR 2'h0
`define AVR_RANGE_LIVEZERO 2'h1
`define AVR_RANGE_UNIPOLAR 2'h2
`define AVR_CLASS_OK 2'h0
`define AVR_CLASS_HIGH 2'h1
`define AVR_CLASS_LOW 2'h2
`endif

// *** rtl/avr_param.v ***
// Parameter assignment tracker for one channel.
// Assumes prm_valid is high only on the cycle a parameter set arrives.
`timescale 1ns/1ps
`default_nettype none
module avr_param (
   input wire clk_sys,
   input wire sys_rst,
   input wire prm_valid,
   input wire prm_ok,
   input wire [1:0] prm_range,
   input wire prm_diag_range,
   output reg ever_ok_q,
   output reg assigned_q,
   output reg bad_q,
   output reg [1:0] range_q,
   output reg diag_range_q
);
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ever_ok_q <= 1'b0;
         assigned_q <= 1'b0;
         bad_q <= 1'b0;
         range_q <= 2'h0;
         diag_range_q <= 1'b0;
      end
      else if (prm_valid)
      begin
         assigned_q <= 1'b1;
         bad_q <= ~prm_ok;
         // A bad set never replaces the last good one
         if (prm_ok)
         begin
            ever_ok_q <= 1'b1;
            range_q <= prm_range;
            diag_range_q <= prm_diag_range;
         end
      end
   end
endmodule // avr_param
`default_nettype wire

// *** rtl/avr_top.v ***
// Analog value range handler: one input and one output channel.
// Assumes converter and controller values arrive with one-cycle valid strobes.
`timescale 1ns/1ps
`default_nettype none
`include "avr_defs.vh"
module avr_top (
   input wire clk_sys,
   input wire sys_rst,
   input wire grp_diag_en,
   input wire ai_prm_valid,
   input wire ai_prm_ok,
   input wire [1:0] ai_prm_range,
   input wire ai_prm_diag_range,
   input wire ao_prm_valid,
   input wire ao_prm_ok,
   input wire [1:0] ao_prm_range,
   input wire ai_adc_valid,
   input wire [15:0] ai_adc_code,
   input wire ao_ctl_valid,
   input wire [15:0] ao_ctl_value,
   output reg [15:0] ai_report_q,
   output reg ai_report_valid_q,
   output reg [15:0] ao_drive_q,
   output reg ao_drive_valid_q,
   output reg group_fault_indicator_q,
   output reg diag_record_q,
   output reg diag_irq_q
);
   wire ai_ever_ok;
   wire ai_assigned;
   wire ai_bad;
   wire [1:0] ai_range;
   wire ai_diag_range;
   wire ao_ever_ok;
   wire ao_assigned;
   wire ao_bad;
   wire [1:0] ao_range;
   wire [1:0] ai_cls;
   wire [1:0] ao_cls;
   wire [3:0] ai_state;
   wire [3:0] ao_state;
   wire ai_prm_fault;
   wire ao_prm_fault;
   wire prm_fault;
   wire range_diag;
   wire range_diag_prev;
   reg ai_range_fault_q;
   reg ai_range_fault_d;
   reg [15:0] ai_report_d;
   reg [15:0] ao_drive_d;
   reg ai_prm_new_d;
   reg ao_prm_new_d;
   reg range_new_d;
   reg diag_event_d;
   reg lamp_d;
   reg ai_prm_prev_q;
   reg ao_prm_prev_q;

   avr_param u_ai_prm (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .prm_valid(ai_prm_valid),
      .prm_ok(ai_prm_ok),
      .prm_range(ai_prm_range),
      .prm_diag_range(ai_prm_diag_range),
      .ever_ok_q(ai_ever_ok),
      .assigned_q(ai_assigned),
      .bad_q(ai_bad),
      .range_q(ai_range),
      .diag_range_q(ai_diag_range)
   );

   avr_param u_ao_prm (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .prm_valid(ao_prm_valid),
      .prm_ok(ao_prm_ok),
      .prm_range(ao_prm_range),
      .prm_diag_range(1'b0),
      .ever_ok_q(ao_ever_ok),
      .assigned_q(ao_assigned),
      .bad_q(ao_bad),
      .range_q(ao_range),
      .diag_range_q()
   );

   avr_classify u_ai_cls (
      .code(ai_adc_code),
      .range_sel(ai_range),
      .cls(ai_cls)
   );

   avr_classify u_ao_cls (
      .code(ao_ctl_value),
      .range_sel(ao_range),
      .cls(ao_cls)
   );

   // Channel condition, decoded from the parameter tracker
   localparam [3:0] CH_UNSET = 4'b0001;
   localparam [3:0] CH_RUN = 4'b0010;
   localparam [3:0] CH_BAD_FIRST = 4'b0100;
   localparam [3:0] CH_BAD_LATE = 4'b1000;

   // Shared by both channels so their decode cannot drift apart
   function [3:0] chan_state;
      input assigned;
      input ever_ok;
      input bad;
      begin
         if (!assigned)
            chan_state = CH_UNSET;
         else if (!ever_ok)
            chan_state = CH_BAD_FIRST;
         else if (bad)
            chan_state = CH_BAD_LATE;
         else
            chan_state = CH_RUN;
      end
   endfunction

   // High for the first cycle of a fault only
   function rise;
      input now;
      input was;
      begin
         rise = now & ~was;
      end
   endfunction

   // Code reported for a sample of a running input channel
   function [15:0] ai_pick;
      input [1:0] cls;
      input [15:0] code;
      begin
         case (cls)
            `AVR_CLASS_HIGH: ai_pick = `AVR_CODE_OVERFLOW;
            `AVR_CLASS_LOW: ai_pick = `AVR_CODE_UNDERFLOW;
            default: ai_pick = code;
         endcase
      end
   endfunction

   assign ai_state = chan_state(ai_assigned, ai_ever_ok, ai_bad);
   assign ao_state = chan_state(ao_assigned, ao_ever_ok, ao_bad);

   // Per-channel faults, so one channel's fault cannot swallow the other's record
   assign ai_prm_fault = (ai_state == CH_BAD_FIRST) || (ai_state == CH_BAD_LATE);
   assign ao_prm_fault = (ao_state == CH_BAD_FIRST) || (ao_state == CH_BAD_LATE);
   assign prm_fault = ai_prm_fault | ao_prm_fault;

   // Input path
   always @*
   begin
      ai_report_d = ai_report_q;
      ai_range_fault_d = ai_range_fault_q;
      if (ai_adc_valid)
      begin
         case (ai_state)
            CH_RUN, CH_BAD_LATE:
            begin
               // A bad set after a good one keeps measuring
               ai_report_d = ai_pick(ai_cls, ai_adc_code);
               ai_range_fault_d = (ai_cls != `AVR_CLASS_OK);
            end
            default:
            begin
               // Unassigned or bad first set both report overflow code
               ai_report_d = `AVR_CODE_OVERFLOW;
               ai_range_fault_d = 1'b0;
            end
         endcase
      end
   end

   // Output path
   always @*
   begin
      ao_drive_d = ao_drive_q;
      if (ao_ctl_valid)
      begin
         case (ao_state)
            CH_RUN, CH_BAD_LATE:
            begin
               if (ao_cls == `AVR_CLASS_OK)
                  ao_drive_d = ao_ctl_value;
               else
                  ao_drive_d = `AVR_CODE_ZERO;
            end
            default:
               ao_drive_d = `AVR_CODE_ZERO;
         endcase
      end
   end

   // Range faults report only with both enables; parameter faults always
   assign range_diag = ai_range_fault_d & grp_diag_en & ai_diag_range;
   assign range_diag_prev = ai_range_fault_q & grp_diag_en & ai_diag_range;

   // One record per new fault, not one per sample
   // A fault that stays up sends no second record, even after a repeat bad set
   always @*
   begin
      ai_prm_new_d = rise(ai_prm_fault, ai_prm_prev_q);
      ao_prm_new_d = rise(ao_prm_fault, ao_prm_prev_q);
      range_new_d = rise(range_diag, range_diag_prev);
      diag_event_d = ai_prm_new_d | ao_prm_new_d | range_new_d;
   end

   // Output range faults never light the lamp; input range faults do even with enables off
   always @*
   begin
      lamp_d = ai_range_fault_d | prm_fault;
   end

   // Input path registers
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         // Same code as an unassigned channel
         ai_report_q <= `AVR_CODE_OVERFLOW;
         ai_report_valid_q <= 1'b0;
         ai_range_fault_q <= 1'b0;
      end
      else
      begin
         ai_report_q <= ai_report_d;
         ai_report_valid_q <= ai_adc_valid;
         ai_range_fault_q <= ai_range_fault_d;
      end
   end

   // Output path registers
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ao_drive_q <= `AVR_CODE_ZERO;
         ao_drive_valid_q <= 1'b0;
      end
      else
      begin
         ao_drive_q <= ao_drive_d;
         ao_drive_valid_q <= ao_ctl_valid;
      end
   end

   // Edge memory for the parameter fault pulses
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ai_prm_prev_q <= 1'b0;
         ao_prm_prev_q <= 1'b0;
      end
      else
      begin
         ai_prm_prev_q <= ai_prm_fault;
         ao_prm_prev_q <= ao_prm_fault;
      end
   end

   // Fault lamp
   always @(posedge clk_sys)
   begin
      if (sys_rst)
         group_fault_indicator_q <= 1'b0;
      else
         group_fault_indicator_q <= lamp_d;
   end

   // Record and interrupt always leave together
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         diag_record_q <= 1'b0;
         diag_irq_q <= 1'b0;
      end
      else
      begin
         diag_record_q <= diag_event_d;
         diag_irq_q <= diag_event_d;
      end
   end
endmodule // avr_top
`default_nettype wire

// *** verification/avr_ioc_model.sv ***
// Controller side: latches every reported input value.
// Assumes report strobes come from avr_top on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module avr_ioc_model (
   input wire logic clk_sys,
   input wire logic ai_report_valid_q,
   input wire logic [15:0] ai_report_q,
   output logic [15:0] got_q
);
   // Only strobed words count, held value is ignored
   always @(posedge clk_sys)
      if (ai_report_valid_q)
         got_q <= ai_report_q;
endmodule // avr_ioc_model
`default_nettype wire

// *** verification/avr_top_chk.sv ***
// Port checker for avr_top.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module avr_chk (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic ai_prm_valid,
   input wire logic ai_prm_ok,
   input wire logic ao_prm_valid,
   input wire logic ao_prm_ok,
   input wire logic ai_adc_valid,
   input wire logic [15:0] ai_adc_code,
   input wire logic ao_ctl_valid,
   input wire logic [15:0] ao_ctl_value,
   input wire logic [15:0] ai_report_q,
   input wire logic ai_report_valid_q,
   input wire logic [15:0] ao_drive_q,
   input wire logic ao_drive_valid_q,
   input wire logic group_fault_indicator_q,
   input wire logic diag_record_q,
   input wire logic diag_irq_q
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   // Lamp lags a bad set by two edges
   sequence s_ai_bad;
      ai_prm_valid && !ai_prm_ok ##1 !ai_prm_valid;
   endsequence
   sequence s_ao_bad;
      ao_prm_valid && !ao_prm_ok ##1 !ao_prm_valid;
   endsequence
   a_ai_lat: assert property (ai_adc_valid |=> ai_report_valid_q) else $error("ai late");
   a_ao_lat: assert property (ao_ctl_valid |=> ao_drive_valid_q) else $error("ao late");
   a_diag_pair: assert property (diag_record_q == diag_irq_q) else $error("irq split");
   a_ai_ovf: assert property (ai_adc_valid && ai_adc_code[15:8] == 8'h7f
      |=> ai_report_q == 16'h7fff) else $error("ai ovf");
   a_ao_ovf: assert property (ao_ctl_valid && ao_ctl_value[15:8] == 8'h7f
      |=> ao_drive_q == 16'h0000) else $error("ao ovf");
   a_diag_lamp: assert property (diag_record_q |-> group_fault_indicator_q)
      else $error("diag no lamp");
   a_ai_bad: assert property (s_ai_bad |=> group_fault_indicator_q) else $error("ai set");
   a_ao_bad: assert property (s_ao_bad |=> group_fault_indicator_q) else $error("ao set");
endmodule // avr_chk
`default_nettype wire

// *** verification/avr_top_tb.sv ***
// Bench for avr_top with controller model.
// Assumes a 40 MHz clock and design files on the path.
`timescale 1ns/1ps
`default_nettype none
module avr_top_tb;
   logic clk_sys = 0;
   logic sys_rst = 1;
   logic grp_diag_en = 1;
   logic ai_prm_valid = 0, ai_prm_ok = 0, ai_prm_diag_range = 1, ao_prm_valid = 0, ao_prm_ok = 0;
   logic [1:0] ai_prm_range = 0, ao_prm_range = 0;
   logic ai_adc_valid = 0, ao_ctl_valid = 0;
   logic [15:0] ai_adc_code = 0, ao_ctl_value = 0, c;
   wire [15:0] ai_report_q, ao_drive_q, got_q;
   wire ai_report_valid_q, ao_drive_valid_q, group_fault_indicator_q, diag_record_q, diag_irq_q;
   int err_count = 0, tests_run = 0;
   integer seed = 32'hd69008d8;
   logic [15:0] cor [10] = '{16'h7eff, 16'h7f00, 16'h8100, 16'h80ff, 16'he500, 16'he4ff,
      16'h0000, 16'hffff, 16'h6c00, 16'h8000};
   avr_top i_dut (.*);
   avr_ioc_model i_ioc (.*);
   initial forever #12.5 clk_sys = ~clk_sys;
   function automatic bit bad(input [15:0] v, input [1:0] r);
      bad = $signed(v) > 16'sh7eff ||
         $signed(v) < $signed(r == 2'd1 ? 16'he500 : r == 2'd2 ? 16'h0000 : 16'h8100);
   endfunction
   task automatic chk(input [15:0] seen, input [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
         err_count++;
      end
   endtask
   // One word per call, valid drops on the taking edge
   task automatic stb(input bit o, input [15:0] v);
      @(posedge clk_sys);
      ai_adc_valid <= !o;
      ao_ctl_valid <= o;
      ai_adc_code <= v;
      ao_ctl_value <= v;
      @(posedge clk_sys);
      ai_adc_valid <= 0;
      ao_ctl_valid <= 0;
      #1;
   endtask
   task automatic prm(input bit o, input bit ok, input [1:0] r);
      @(posedge clk_sys);
      ai_prm_valid <= !o;
      ao_prm_valid <= o;
      ai_prm_ok <= ok;
      ao_prm_ok <= ok;
      ai_prm_range <= r;
      ao_prm_range <= r;
      @(posedge clk_sys);
      ai_prm_valid <= 0;
      ao_prm_valid <= 0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 0;
      stb(0, 16'h1234);
      chk(ai_report_q, 16'h7fff);
      chk(16'(group_fault_indicator_q), 16'h0000);
      chk(16'({ai_report_valid_q, ao_drive_valid_q}), 16'h0002);
      stb(1, 16'h1234);
      chk(ao_drive_q, 16'h0000);
      chk(16'({ai_report_valid_q, ao_drive_valid_q}), 16'h0001);
      prm(1, 0, 0);
      chk(16'(diag_irq_q), 16'h0001);
      stb(1, 16'h0100);
      chk(ao_drive_q, 16'h0000);
      @(posedge clk_sys);
      grp_diag_en <= 0;
      prm(0, 0, 0);
      chk(16'(diag_record_q), 16'h0001);
      stb(0, 16'h0100);
      chk(ai_report_q, 16'h7fff);
      @(posedge clk_sys);
      grp_diag_en <= 1;
      for (int r = 0; r < 4; r++)
      begin
         prm(0, 1, r[1:0]);
         prm(1, 1, r[1:0]);
         for (int i = 0; i < 40; i++)
         begin
            c = i < 10 ? cor[i] : 16'($random(seed));
            stb(0, c);
            chk(16'(group_fault_indicator_q), 16'(bad(c, r[1:0])));
            stb(1, c);
            chk(got_q, !bad(c, r[1:0]) ? c : c[15] ? 16'h8000 : 16'h7fff);
            chk(ao_drive_q, bad(c, r[1:0]) ? 16'h0000 : c);
         end
      end
      prm(0, 1, 0);
      stb(0, 0);
      stb(0, 16'h7fff);
      chk(16'(diag_irq_q), 16'h0001);
      @(posedge clk_sys);
      grp_diag_en <= 0;
      stb(0, 0);
      stb(0, 16'h8000);
      chk(16'(diag_irq_q), 16'h0000);
      chk(ai_report_q, 16'h8000);
      stb(0, 0);
      prm(0, 0, 2);
      chk(16'(diag_record_q), 16'h0001);
      // Bipolar set stays, so ffff still passes
      stb(0, 16'hffff);
      chk(ai_report_q, 16'hffff);
      chk(16'(group_fault_indicator_q), 16'h0001);
      prm(1, 0, 2);
      chk(16'(diag_irq_q), 16'h0001);
      stb(1, 16'hffff);
      chk(ao_drive_q, 16'hffff);
      test_done;
   end
   // Run needs about 710 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      test_done;
   end
endmodule // avr_top_tb
bind avr_top avr_chk i_chk (.*);
`default_nettype wire
